// file: verilog/brs_fabric_ctl.sv
`timescale 1ns/1ps
`include "brs_map.svh"
// fabric controller: orders enables around every user-requested asynchronous reset
module brs_fabric_ctl #(
  parameter int ADDR_W = `BRS_ADDR_W,
  parameter int DATA_W = `BRS_DATA_W,
  parameter int QUIET_CYC = `BRS_QUIET_CYC,
  parameter int HOLD_CYC = `BRS_HOLD_CYC,
  parameter bit PRELOADED = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic usr_en,
  input wire logic usr_wr,
  input wire logic usr_rd,
  input wire logic [ADDR_W-1:0] usr_addr,
  input wire logic [DATA_W-1:0] usr_wdata,
  input wire logic usr_rst_req,
  input wire logic usr_gsr_req,
  input wire logic usr_fifo_rst_req,
  input wire logic usr_rp_rst_req,
  input wire logic usr_sync_rst,
  input wire logic io_wake,
  output logic usr_busy,
  output logic [DATA_W-1:0] usr_rdata,
  brs_if.ctl link
);
  brs_pkg::brs_seq_e st_r, st_nxt;
  logic [7:0] cnt_r;
  logic [3:0] kind_r; // which resets this sequence drives
  logic [DATA_W-1:0] rdata_r;
  logic gsr_boot_r;

  wire [3:0] req = {usr_rp_rst_req, usr_fifo_rst_req, usr_gsr_req, usr_rst_req};
  wire any_req = |req;
  wire cnt_done = (cnt_r == 8'h00);
  wire quiet = (st_r != brs_pkg::BRS_IDLE);

  // state sequence: quiet, reset, quiet, back to idle
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      brs_pkg::BRS_IDLE: if (any_req) st_nxt = brs_pkg::BRS_QUIET_PRE;
      brs_pkg::BRS_QUIET_PRE: if (cnt_done) st_nxt = brs_pkg::BRS_IN_RESET;
      brs_pkg::BRS_IN_RESET: if (cnt_done) st_nxt = brs_pkg::BRS_QUIET_POST;
      brs_pkg::BRS_QUIET_POST: if (cnt_done) st_nxt = brs_pkg::BRS_IDLE;
      default: st_nxt = brs_pkg::BRS_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= brs_pkg::BRS_IDLE;
      cnt_r <= 8'h00;
      kind_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      if (!quiet && any_req) begin
        kind_r <= req;
        cnt_r <= 8'(QUIET_CYC - 1);
      end else if (st_nxt != st_r) begin
        cnt_r <= (st_nxt == brs_pkg::BRS_IN_RESET) ? 8'(HOLD_CYC - 1) : 8'(QUIET_CYC - 1);
      end else if (!cnt_done) begin
        cnt_r <= cnt_r - 8'h01;
      end
    end
  end

  // preloaded contents: global reset held from boot until io wake
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gsr_boot_r <= PRELOADED;
    end else if (io_wake) begin
      gsr_boot_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= link.rd_data;
    end
  end

  wire in_rst = (st_r == brs_pkg::BRS_IN_RESET);
  wire [3:0] rst_vec;
  // one strobe per reset kind, all framed by the same hold state
  for (genvar i = 0; i < 4; i++) begin : g_rst
    assign rst_vec[i] = in_rst & kind_r[i];
  end
  // enables and requests forced low through the whole sequence
  assign link.clk_en = usr_en & ~quiet & ~gsr_boot_r;
  assign link.wr_req = usr_wr & ~quiet & ~gsr_boot_r;
  assign link.fifo_read_request = usr_rd & ~quiet & ~gsr_boot_r;
  assign link.mem_async_rst = rst_vec[0];
  assign link.global_set_reset = rst_vec[1] | gsr_boot_r;
  assign link.fifo_rst = rst_vec[2];
  assign link.fifo_read_pointer_reset = rst_vec[3];
  assign link.sync_rst = usr_sync_rst;
  assign link.addr = usr_addr;
  assign link.wr_data = usr_wdata;
  assign usr_busy = quiet | gsr_boot_r;
  assign usr_rdata = rdata_r;
endmodule // brs_fabric_ctl

// file: inc/brs_map.svh
`ifndef BRS_MAP_SVH
`define BRS_MAP_SVH
`define BRS_ADDR_W 8
`define BRS_DATA_W 9
`define BRS_QUIET_CYC 1
`define BRS_HOLD_CYC 2
`define BRS_CFG_RAM 2'h0
`define BRS_CFG_ROM 2'h1
`define BRS_CFG_FIFO 2'h2
`endif

// file: inc/brs_pkg.sv
package brs_pkg;
  typedef enum logic [1:0] {
    BRS_IDLE,
    BRS_QUIET_PRE,
    BRS_IN_RESET,
    BRS_QUIET_POST
  } brs_seq_e;
  typedef logic [1:0] brs_cfg_t;
endpackage

// file: inc/brs_if.sv
`timescale 1ns/1ps
// link between the fabric controller and the block memory
interface brs_if;
  logic clk_en;
  logic wr_req;
  logic fifo_read_request;
  logic mem_async_rst;
  logic global_set_reset;
  logic fifo_rst;
  logic fifo_read_pointer_reset;
  logic sync_rst;
  logic [7:0] addr;
  logic [8:0] wr_data;
  logic [8:0] rd_data;
  logic fifo_empty;
  logic fifo_full;
  modport mem (
    input clk_en, wr_req, fifo_read_request, mem_async_rst, global_set_reset,
    input fifo_rst, fifo_read_pointer_reset, sync_rst, addr, wr_data,
    output rd_data, fifo_empty, fifo_full
  );
  modport ctl (
    output clk_en, wr_req, fifo_read_request, mem_async_rst, global_set_reset,
    output fifo_rst, fifo_read_pointer_reset, sync_rst, addr, wr_data,
    input rd_data, fifo_empty, fifo_full
  );
endinterface

// file: verilog/brs_embedded_block_ram.sv
`timescale 1ns/1ps
`include "brs_map.svh"
// embedded_block_ram end: ram, rom or fifo with asynchronous resets
module brs_embedded_block_ram #(
  parameter int ADDR_W = `BRS_ADDR_W,
  parameter int DATA_W = `BRS_DATA_W,
  parameter logic [1:0] CFG_MODE = `BRS_CFG_RAM,
  parameter bit GSR_ENABLE = 1'b1
) (
  input wire logic clk,
  input wire logic sys_rst,
  brs_if.mem link
);
  localparam int DEPTH = 1 << ADDR_W;
  wire is_fifo = (CFG_MODE == `BRS_CFG_FIFO);
  // fifo mode cannot switch global reset off
  wire gsr_use = is_fifo ? 1'b1 : GSR_ENABLE;
  // any asynchronous source clears outputs and the read pointer; all but the read-pointer reset clear the write pointer too
  wire gsr_hit = gsr_use & link.global_set_reset;
  wire fifo_hit = is_fifo & link.fifo_rst;
  wire arst = sys_rst | link.mem_async_rst | gsr_hit | fifo_hit;
  wire rp_arst = arst | (is_fifo & link.fifo_read_pointer_reset);

  logic [DATA_W-1:0] mem_r [DEPTH];
  logic [ADDR_W:0] wp_r;
  logic [ADDR_W:0] rp_r;
  logic [DATA_W-1:0] rd_r;

  // write and read requests stand in for clock enables in fifo mode
  wire full = (wp_r[ADDR_W] != rp_r[ADDR_W]) && (wp_r[ADDR_W-1:0] == rp_r[ADDR_W-1:0]);
  wire empty = (wp_r == rp_r);
  wire ram_wr = link.wr_req & link.clk_en & (CFG_MODE == `BRS_CFG_RAM); // rom never writes
  wire do_wr = is_fifo ? (link.wr_req & ~full) : ram_wr;
  wire do_rd = is_fifo ? (link.fifo_read_request & ~empty) : link.clk_en;
  wire [ADDR_W-1:0] wa = is_fifo ? wp_r[ADDR_W-1:0] : link.addr;
  wire [ADDR_W-1:0] ra = is_fifo ? rp_r[ADDR_W-1:0] : link.addr;

  // storage has no reset, like a real memory array
  always_ff @(posedge clk) begin
    if (do_wr & ~arst) begin
      mem_r[wa] <= link.wr_data;
    end
  end

  // write pointer, cleared without a clock edge
  always_ff @(posedge clk or posedge arst) begin
    if (arst) begin
      wp_r <= '0;
    end else if (do_wr && is_fifo) begin
      wp_r <= wp_r + 1'b1;
    end
  end

  // read pointer also cleared by its own reset
  always_ff @(posedge clk or posedge rp_arst) begin
    if (rp_arst) begin
      rp_r <= '0;
    end else if (do_rd && is_fifo) begin
      rp_r <= rp_r + 1'b1;
    end
  end

  // output register, also takes the synchronous reset
  // a read-pointer rewind clears it too, so no stale word survives any reset
  always_ff @(posedge clk or posedge rp_arst) begin
    if (rp_arst) begin
      rd_r <= '0;
    end else if (link.sync_rst) begin
      rd_r <= '0;
    end else if (do_rd) begin
      rd_r <= mem_r[ra];
    end
  end

  assign link.rd_data = rd_r;
  assign link.fifo_empty = empty;
  assign link.fifo_full = full;
endmodule // brs_embedded_block_ram

// file: tb/brs_link_props.sv
`timescale 1ns/1ps
// enable-quiet framing of every async reset on the link
module brs_link_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic wr_req,
  input wire logic fifo_read_request,
  input wire logic mem_async_rst,
  input wire logic global_set_reset,
  input wire logic fifo_rst,
  input wire logic fifo_read_pointer_reset,
  input wire logic [8:0] rd_data,
  input wire logic fifo_empty,
  input wire logic fifo_full
);
  // any reset, idle requests, all enables idle
  wire any_rst = mem_async_rst | global_set_reset | fifo_rst | fifo_read_pointer_reset;
  wire no_req = !wr_req && !fifo_read_request;
  wire quiet = no_req && !clk_en;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_hold; any_rst ##1 any_rst ##1 !any_rst && quiet; endsequence
  sequence s_idle; no_req && !any_rst ##1 !any_rst; endsequence
  a_pre_quiet: assert property ($rose(any_rst) |-> $past(quiet))
    else $error("live enable");
  a_post_quiet: assert property ($fell(any_rst) |-> quiet)
    else $error("early enable");
  a_rst_hold: assert property ($rose(any_rst) |-> s_hold)
    else $error("bad hold");
  a_rp_quiet: assert property ($rose(fifo_read_pointer_reset) |-> !$past(fifo_read_request))
    else $error("read at rewind");
  a_fifo_quiet: assert property ($fell(fifo_rst) |-> no_req)
    else $error("request at release");
  a_clear_data: assert property (any_rst |-> rd_data == 9'h000)
    else $error("data kept");
  a_rst_empty: assert property ((fifo_rst || global_set_reset) |-> fifo_empty)
    else $error("not empty");
  a_idle_stable: assert property (s_idle |-> $stable(fifo_empty))
    else $error("flag moved");
  a_rst_notfull: assert property ((fifo_rst || global_set_reset) |-> !fifo_full)
    else $error("full under reset");
endmodule // brs_link_props

// file: tb/block_ram_async_reset_sequencer_tb.sv
`timescale 1ns/1ps
// controller driving a fifo-mode memory end to end
module block_ram_async_reset_sequencer_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic srst = 1'b0;
  logic [3:0] req = 4'h0;
  logic [8:0] wdata = 9'h000;
  logic busy;
  logic [8:0] rdata;
  int err_count = 0;
  int checks = 0;
  brs_if link ();
  brs_fabric_ctl i_brs_fabric_ctl (.clk(clk), .sys_rst(sys_rst), .usr_en(1'b1), .usr_wr(wr),
    .usr_rd(rd), .usr_addr(8'h00), .usr_wdata(wdata), .usr_rst_req(req[0]),
    .usr_gsr_req(req[1]), .usr_fifo_rst_req(req[2]), .usr_rp_rst_req(req[3]),
    .usr_sync_rst(srst), .io_wake(1'b1), .usr_busy(busy), .usr_rdata(rdata), .link(link));
  brs_embedded_block_ram #(.CFG_MODE(2'h2)) i_brs_embedded_block_ram (.clk(clk),
    .sys_rst(sys_rst), .link(link));
  brs_link_props i_brs_link_props (.clk(clk), .sys_rst(sys_rst), .clk_en(link.clk_en),
    .wr_req(link.wr_req), .fifo_read_request(link.fifo_read_request),
    .mem_async_rst(link.mem_async_rst), .global_set_reset(link.global_set_reset),
    .fifo_rst(link.fifo_rst), .fifo_read_pointer_reset(link.fifo_read_pointer_reset),
    .rd_data(link.rd_data), .fifo_empty(link.fifo_empty), .fifo_full(link.fifo_full));
  initial forever #2.5 clk = ~clk;
  // inputs move 1 ns after the edge so no race with the design
  task automatic step(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d, checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic push(input logic [8:0] d);
    wr = 1'b1;
    wdata = d;
    step();
    wr = 1'b0;
    step(); // idle cycle so a following push never re-raises wr in the same step
  endtask
  // read data shows two edges after the request
  task automatic pop(input logic [8:0] exp);
    rd = 1'b1;
    step();
    rd = 1'b0;
    step();
    chk("usr_rdata", exp, rdata);
  endtask
  // write stays requested through the sequence; busy must mask it
  task automatic t_rst(input int k, input logic exp_empty);
    int n;
    n = 0;
    wr = 1'b1;
    wdata = 9'h0f0;
    req[k] = 1'b1;
    step();
    req[k] = 1'b0;
    while (busy === 1'b1 && n < 20) begin
      n++;
      step();
    end
    wr = 1'b0;
    chk("busy", 9'h004, n[8:0]);
    chk("fifo_empty", {8'h00, exp_empty}, {8'h00, link.fifo_empty});
    step(); // let wr stay low across one edge before the next call
  endtask
  // two writes then one read through the fifo
  task automatic t_fill;
    push(9'h1a5);
    push(9'h05a);
    pop(9'h1a5);
  endtask
  // synchronous clear needs no quiet window and empties the output register
  task automatic t_sync;
    srst = 1'b1;
    step();
    chk("busy", 9'h000, {8'h00, busy});
    srst = 1'b0;
    step();
    chk("usr_rdata", 9'h000, rdata);
  endtask
  // rewind replays every word once, nothing written while busy
  task automatic t_rewind;
    pop(9'h1a5);
    pop(9'h05a);
    pop(9'h0f0);
    chk("fifo_empty", 9'h001, {8'h00, link.fifo_empty});
  endtask
  initial begin
    step(10);
    sys_rst = 1'b0;
    step();
    t_fill();
    t_rst(3, 1'b0);
    t_rewind();
    t_sync();
    for (int k = 2; k >= 0; k--) t_rst(k, 1'b1);
    stop_test();
  end
  // run needs about 50 cycles; allow eight times that
  initial begin
    #2000;
    err_count++;
    stop_test();
  end
endmodule // block_ram_async_reset_sequencer_tb
